//--- shared/lmg_defs.vh
// Constants for the link interrupt mask gate: register offsets, field positions and reset values.
// Assumes a 32-bit APB register bus with byte addresses.
`ifndef LMG_DEFS_VH
`define LMG_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LMG_OFS_MASK_SET     8'h88
`define LMG_OFS_MASK_CLR     8'h8C
`define LMG_OFS_EVT_STAT     8'h90
`define LMG_OFS_EVT_MASK     8'h94
`define LMG_OFS_TX_CTX_MASK  8'h98
`define LMG_OFS_RX_CTX_MASK  8'h9C

// ----------------------------------------------------------------
// Mask field layout
// ----------------------------------------------------------------
`define LMG_BIT_GLOBAL_GATE  31
`define LMG_BIT_MAKER_EXTRA  30
`define LMG_BIT_SOFT_EVENT   29
`define LMG_BIT_TIMED_RX     7
`define LMG_BIT_TIMED_TX     6
// Writable bits: all but 28 and 14..10
`define LMG_MASK_WRITABLE    32'hEFFF_83FF
`define LMG_MASK_RESET       32'h0000_0000

// ----------------------------------------------------------------
// Block status event layout
// ----------------------------------------------------------------
`define LMG_STAT_WIDTH       2
`define LMG_STAT_IRQ_RISE    0
`define LMG_STAT_GATE_FALL   1
`define LMG_STAT_RESET       2'h0
`define LMG_CTX_RESET        8'h00

`endif

//--- rtl/lmg_sync2.v
// Two-flop synchroniser for a bus of asynchronous level inputs.
// Assumes inputs are quasi-static levels; no data coherence across bits.
module lmg_sync2 #(
  parameter WIDTH = 32
) (
  input  wire             clk_in,
  input  wire             reset_n_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // lmg_sync2

//--- rtl/lmg_ctx_summary.v
// Non-latched summary of per-context timed events against their per-context masks.
// Assumes event and mask inputs are synchronous to clk_in.
module lmg_ctx_summary #(
  parameter CTX = 8
) (
  input  wire           clk_in,
  input  wire           reset_n_in,
  input  wire [CTX-1:0] ctx_event_in,
  input  wire [CTX-1:0] ctx_mask_in,
  output wire           summary_out
);
  wire [CTX-1:0] hit;
  reg            summary_q;

  genvar g;
  generate
    for (g = 0; g < CTX; g = g + 1) begin : g_ctx
      assign hit[g] = ctx_event_in[g] & ctx_mask_in[g];
    end
  endgenerate

  // Registered so the summary is a clean flop output; follows the inputs, never latches
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= |hit;
    end
  end

  assign summary_out = summary_q;
endmodule // lmg_ctx_summary

//--- rtl/lmg_mask_gate.v
// Interrupt mask gate for a serial link-layer host controller, APB register slave.
// Assumes event levels arrive asynchronously and are synchronised here; one clock.
//
// Behaviour
// - Mask has a set view at 0x88 and a clear view at 0x8C.
// - Reads of either view return the mask unchanged, no side effect.
// - With global gate bit 31 set, any event ANDed with mask raises interrupt.
// - With global gate clear, the external interrupt stays inactive.
// - Mask bits other than 31 align with event bit positions.
// - Mask bit 30 enables the maker extra event bit 30.
// - Mask bit 29 enables the software raised event bit 29.
// - Mask bit 28 reserved, read-only, reads zero.
// - Mask bits 14 to 10 reserved, read-only, read zero.
// - Bits 27, 26, 24 enable late ack, line reg received, fatal fault.
// - Bits 25, 23..20 enable the period timing events.
// - Bits 19..15 enable line status, access failure, reset, node ident events.
// - Bits 9 and 8 enable atomic reply fault and deferred store fault.
// - Bits 7 and 6 enable timed receive and transmit summaries.
// - Bits 5..0 enable packet arrival, rx DMA and send done events.
// - Event bits 7 and 6 are non-latched ORs of masked per-context events.
//
// The implementer's own choice: the APB slave port.
`include "lmg_defs.vh"

module lmg_mask_gate #(
  parameter CTX = 8
) (
  input  wire            CLK_IN,
  input  wire            RESET_N_IN,
  // APB slave
  input  wire            PSEL_IN,
  input  wire            PENABLE_IN,
  input  wire            PWRITE_IN,
  input  wire [7:0]      PADDR_IN,
  input  wire [31:0]     PWDATA_IN,
  input  wire [3:0]      PSTRB_IN,
  output wire            PREADY_OUT,
  output reg  [31:0]     PRDATA_OUT,
  output wire            PSLVERR_OUT,
  // Event sources
  input  wire [31:0]     EVENT_IN,
  input  wire [CTX-1:0]  TX_CTX_EVENT_IN,
  input  wire [CTX-1:0]  RX_CTX_EVENT_IN,
  // Outputs
  output reg             HOST_IRQ_OUT,
  output wire            BLOCK_IRQ_OUT,
  output wire [31:0]     MASK_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_addr;
    input [7:0] a;
    input [7:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  function [31:0] strb_bits;
    input [3:0] s;
    begin
      strb_bits = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [31:0]                mask_q;
  reg  [31:0]                mask_d;
  reg  [CTX-1:0]             tx_ctx_mask_q;
  reg  [CTX-1:0]             rx_ctx_mask_q;
  reg  [`LMG_STAT_WIDTH-1:0] stat_q;
  reg  [`LMG_STAT_WIDTH-1:0] stat_d;
  reg  [`LMG_STAT_WIDTH-1:0] stat_en_q;
  reg                        gate_prev_q;
  reg                        irq_prev_q;
  reg  [31:0]                rd_d;
  reg                        hit_d;

  wire [31:0]    ev_sync;
  wire [CTX-1:0] tx_sync;
  wire [CTX-1:0] rx_sync;
  wire           tx_sum;
  wire           rx_sum;
  wire [31:0]    ev_all;
  wire [31:0]    wmask;
  wire           acc;
  wire           wr;
  wire           irq_d;
  wire [`LMG_STAT_WIDTH-1:0] stat_ev;

  // ----------------------------------------------------------------
  // Input synchronisers and per-context summaries
  // ----------------------------------------------------------------
  lmg_sync2 #(.WIDTH(32)) u_sync_ev (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .async_in   (EVENT_IN),
    .sync_out   (ev_sync)
  );

  lmg_sync2 #(.WIDTH(CTX)) u_sync_tx (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .async_in   (TX_CTX_EVENT_IN),
    .sync_out   (tx_sync)
  );

  lmg_sync2 #(.WIDTH(CTX)) u_sync_rx (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .async_in   (RX_CTX_EVENT_IN),
    .sync_out   (rx_sync)
  );

  lmg_ctx_summary #(.CTX(CTX)) u_sum_tx (
    .clk_in       (CLK_IN),
    .reset_n_in   (RESET_N_IN),
    .ctx_event_in (tx_sync),
    .ctx_mask_in  (tx_ctx_mask_q),
    .summary_out  (tx_sum)
  );

  lmg_ctx_summary #(.CTX(CTX)) u_sum_rx (
    .clk_in       (CLK_IN),
    .reset_n_in   (RESET_N_IN),
    .ctx_event_in (rx_sync),
    .ctx_mask_in  (rx_ctx_mask_q),
    .summary_out  (rx_sum)
  );

  // Bits 7 and 6 come only from the context summaries, never from the pins
  assign ev_all = {ev_sync[31:`LMG_BIT_TIMED_RX+1], rx_sum, tx_sum,
                   ev_sync[`LMG_BIT_TIMED_TX-1:0]};

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = 1'b0;
  assign acc   = PSEL_IN & PENABLE_IN;
  assign wr    = acc & PWRITE_IN;
  assign wmask = strb_bits(PSTRB_IN) & PWDATA_IN & `LMG_MASK_WRITABLE;

  // ----------------------------------------------------------------
  // Mask register, set and clear views
  // ----------------------------------------------------------------
  always @* begin
    mask_d = mask_q;
    if (wr && is_addr(PADDR_IN, `LMG_OFS_MASK_SET)) begin
      mask_d = mask_q | wmask;
    end else if (wr && is_addr(PADDR_IN, `LMG_OFS_MASK_CLR)) begin
      mask_d = mask_q & ~wmask;
    end
    // Reserved bits are never stored, so they always read zero
    mask_d = mask_d & `LMG_MASK_WRITABLE;
  end

  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mask_q <= `LMG_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Per-context masks: plain read/write
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tx_ctx_mask_q <= `LMG_CTX_RESET;
      rx_ctx_mask_q <= `LMG_CTX_RESET;
    end else begin
      if (wr && is_addr(PADDR_IN, `LMG_OFS_TX_CTX_MASK) && PSTRB_IN[0]) begin
        tx_ctx_mask_q <= PWDATA_IN[CTX-1:0];
      end
      if (wr && is_addr(PADDR_IN, `LMG_OFS_RX_CTX_MASK) && PSTRB_IN[0]) begin
        rx_ctx_mask_q <= PWDATA_IN[CTX-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // External interrupt
  // ----------------------------------------------------------------
  // Aligned events AND enables; the gate bit has no event
  assign irq_d = mask_q[`LMG_BIT_GLOBAL_GATE] &
                 (|(ev_all[`LMG_BIT_MAKER_EXTRA:0] & mask_q[`LMG_BIT_MAKER_EXTRA:0]));

  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      HOST_IRQ_OUT <= 1'b0;
    end else begin
      HOST_IRQ_OUT <= irq_d;
    end
  end

  assign MASK_OUT = mask_q;

  // ----------------------------------------------------------------
  // Block status: sticky, write-one-to-clear, set wins
  // ----------------------------------------------------------------
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      gate_prev_q <= 1'b0;
      irq_prev_q  <= 1'b0;
    end else begin
      gate_prev_q <= mask_q[`LMG_BIT_GLOBAL_GATE];
      irq_prev_q  <= HOST_IRQ_OUT;
    end
  end

  assign stat_ev = {gate_prev_q & ~mask_q[`LMG_BIT_GLOBAL_GATE], HOST_IRQ_OUT & ~irq_prev_q};

  always @* begin
    stat_d = stat_q;
    if (wr && is_addr(PADDR_IN, `LMG_OFS_EVT_STAT) && PSTRB_IN[0]) begin
      stat_d = stat_q & ~PWDATA_IN[`LMG_STAT_WIDTH-1:0];
    end
    stat_d = stat_d | stat_ev;
  end

  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      stat_q    <= `LMG_STAT_RESET;
      stat_en_q <= `LMG_STAT_RESET;
    end else begin
      stat_q <= stat_d;
      if (wr && is_addr(PADDR_IN, `LMG_OFS_EVT_MASK) && PSTRB_IN[0]) begin
        stat_en_q <= PWDATA_IN[`LMG_STAT_WIDTH-1:0];
      end
    end
  end

  assign BLOCK_IRQ_OUT = |(stat_q & stat_en_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    case (PADDR_IN)
      `LMG_OFS_MASK_SET:    rd_d = mask_q;
      `LMG_OFS_MASK_CLR:    rd_d = mask_q;
      `LMG_OFS_EVT_STAT:    rd_d = {{(32-`LMG_STAT_WIDTH){1'b0}}, stat_q};
      `LMG_OFS_EVT_MASK:    rd_d = {{(32-`LMG_STAT_WIDTH){1'b0}}, stat_en_q};
      `LMG_OFS_TX_CTX_MASK: rd_d = {{(32-CTX){1'b0}}, tx_ctx_mask_q};
      `LMG_OFS_RX_CTX_MASK: rd_d = {{(32-CTX){1'b0}}, rx_ctx_mask_q};
      default:              hit_d = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it is stable from the access cycle
  always @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      PRDATA_OUT <= hit_d ? rd_d : 32'h0000_0000;
    end
  end

endmodule // lmg_mask_gate

//--- verification/lmg_mask_gate_sva.sv
// Concurrent checks for the interrupt mask gate, bound onto its top module.
// Assumes full-strobe mask writes and the defs header on the include path.
`include "lmg_defs.vh"
module lmg_mask_gate_chk (
  input wire logic        CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0]  PSTRB_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        HOST_IRQ_OUT,
  input wire logic [31:0] MASK_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  wire wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
  wire on_mask = PADDR_IN == `LMG_OFS_MASK_SET || PADDR_IN == `LMG_OFS_MASK_CLR;

  chk_set_view:
    assert property (wr_acc && PSTRB_IN == 4'hF && PADDR_IN == `LMG_OFS_MASK_SET |=>
      MASK_OUT == ($past(MASK_OUT) | ($past(PWDATA_IN) & `LMG_MASK_WRITABLE))) else $error("Set view write wrong");
  chk_clear_view:
    assert property (wr_acc && PSTRB_IN == 4'hF && PADDR_IN == `LMG_OFS_MASK_CLR |=>
      MASK_OUT == ($past(MASK_OUT) & ~($past(PWDATA_IN) & `LMG_MASK_WRITABLE))) else $error("Clear view write wrong");
  chk_mask_hold:
    assert property (!(wr_acc && on_mask) |=> $stable(MASK_OUT)) else $error("Mask changed without a write");
  chk_read_back:
    assert property (PSEL_IN && !PENABLE_IN && !PWRITE_IN && on_mask |=> PRDATA_OUT == $past(MASK_OUT))
      else $error("Mask read data wrong");
  chk_bit28_zero:
    assert property (MASK_OUT[28] == 1'b0) else $error("Mask bit 28 set");
  chk_low_rsvd_zero:
    assert property (MASK_OUT[14:10] == 5'h00) else $error("Mask bits 14 to 10 set");
  chk_gate_off:
    assert property (!MASK_OUT[31] |=> !HOST_IRQ_OUT) else $error("Interrupt with gate off");
  chk_no_stray_irq:
    assert property (MASK_OUT[30:0] == 31'h0000_0000 |=> !HOST_IRQ_OUT) else $error("Interrupt with no enables");
endmodule // lmg_mask_gate_chk

bind lmg_mask_gate lmg_mask_gate_chk u_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN),
  .PRDATA_OUT(PRDATA_OUT), .HOST_IRQ_OUT(HOST_IRQ_OUT), .MASK_OUT(MASK_OUT));

//--- verification/lmg_host_irq_model.sv
// Host side of the interrupt line: counts assertions of the level request.
// Assumes the request is active high and synchronous to clk_in.
module lmg_host_irq_model (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        irq_in,
  output logic [15:0]      rise_count_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_q          <= 1'b0;
      rise_count_out <= 16'h0000;
    end else begin
      irq_q <= irq_in;
      if (irq_in && !irq_q)
        rise_count_out <= rise_count_out + 16'h0001;
    end
  end
endmodule // lmg_host_irq_model

//--- verification/lmg_mask_gate_tb.sv
// Self-checking bench for the interrupt mask gate: APB master tasks, random and directed events.
// Assumes the defs header on the include path; the checker binds itself.
`include "lmg_defs.vh"
module lmg_mask_gate_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals and expectation helpers
  // ----------------------------------------------------------------
  localparam logic [31:0] EV_USED = 32'h7FFF_FF3F;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, host_irq, block_irq;
  logic [7:0]  paddr, tx_ev, rx_ev;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, ev, mask, exp_m, seed;
  logic [15:0] rises;
  int          err_total, tests_run;

  lmg_mask_gate dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
    .PSLVERR_OUT(pslverr), .EVENT_IN(ev), .TX_CTX_EVENT_IN(tx_ev), .RX_CTX_EVENT_IN(rx_ev),
    .HOST_IRQ_OUT(host_irq), .BLOCK_IRQ_OUT(block_irq), .MASK_OUT(mask));
  lmg_host_irq_model u_host (.clk_in(clk), .reset_n_in(rst_n), .irq_in(host_irq), .rise_count_out(rises));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] next_mask(input logic [31:0] m, input logic [31:0] d, input logic set);
    return set ? (m | (d & `LMG_MASK_WRITABLE)) : (m & ~(d & `LMG_MASK_WRITABLE));
  endfunction
  function automatic logic [31:0] want_irq(input logic [31:0] m, input logic [31:0] e);
    return {31'h0000_0000, m[31] & |(m & e & EV_USED)};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the slave's answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk("read data", exp, q);
  endtask
  task automatic mw(input logic set, input logic [31:0] d);
    wr(set ? `LMG_OFS_MASK_SET : `LMG_OFS_MASK_CLR, d);
    exp_m = next_mask(exp_m, d, set);
  endtask
  // Two sync flops plus the output register, one more edge for the context summary register
  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, ev, tx_ev, rx_ev, exp_m} = '0;
    pstrb = 4'hF;
    seed = 32'h0000_0282;
    err_total = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("mask reset", 32'h0000_0000, mask);
    chk("error flag", 32'h0000_0000, {31'h0000_0000, pslverr});
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      mw(i == 0 || (i > 1 && seed[3]), (i < 2) ? 32'hFFFF_FFFF : lfsr(seed));
      ev <= seed;
      rd(`LMG_OFS_MASK_SET, exp_m);
      rd(`LMG_OFS_MASK_CLR, exp_m);
      settle();
      chk("irq random", want_irq(exp_m, seed), {31'h0000_0000, host_irq});
    end
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    rd(`LMG_OFS_MASK_SET, exp_m);
    for (int b = 0; b < 31; b++) begin
      if (b == 28 || (b >= 10 && b <= 14) || b == 6 || b == 7)
        continue;
      mw(1'b0, 32'hFFFF_FFFF);
      mw(1'b1, 32'h8000_0000 | (32'h0000_0001 << b));
      ev <= 32'h0000_0001 << b;
      settle();
      chk("irq one bit", 32'h0000_0001, {31'h0000_0000, host_irq});
      @(posedge clk);
      ev <= EV_USED & ~(32'h0000_0001 << b);
      settle();
      chk("irq other bits", 32'h0000_0000, {31'h0000_0000, host_irq});
    end
    mw(1'b1, 32'hFFFF_FFFF);
    ev <= 32'hFFFF_FFFF;
    settle();
    chk("irq gate on", 32'h0000_0001, {31'h0000_0000, host_irq});
    mw(1'b0, 32'h8000_0000);
    settle();
    chk("irq gate off", 32'h0000_0000, {31'h0000_0000, host_irq});
    rd(`LMG_OFS_EVT_STAT, 32'h0000_0003);
    wr(`LMG_OFS_EVT_MASK, 32'h0000_0002);
    @(negedge clk);
    chk("block irq on", 32'h0000_0001, {31'h0000_0000, block_irq});
    wr(`LMG_OFS_EVT_MASK, 32'h0000_0000);
    @(negedge clk);
    chk("block irq masked", 32'h0000_0000, {31'h0000_0000, block_irq});
    wr(`LMG_OFS_EVT_STAT, 32'h0000_0003);
    rd(`LMG_OFS_EVT_STAT, 32'h0000_0000);
    ev <= 32'h0000_0000;
    mw(1'b0, 32'hFFFF_FFFF);
    mw(1'b1, 32'h8000_0080);
    wr(`LMG_OFS_RX_CTX_MASK, 32'h0000_0008);
    rx_ev <= 8'h08;
    settle();
    chk("irq rx context", 32'h0000_0001, {31'h0000_0000, host_irq});
    @(posedge clk);
    rx_ev <= 8'h00;
    settle();
    chk("irq rx released", 32'h0000_0000, {31'h0000_0000, host_irq});
    mw(1'b1, 32'h0000_0040);
    tx_ev <= 8'h81;
    wr(`LMG_OFS_TX_CTX_MASK, 32'h0000_0001);
    settle();
    chk("irq tx context", 32'h0000_0001, {31'h0000_0000, host_irq});
    wr(`LMG_OFS_TX_CTX_MASK, 32'h0000_0000);
    settle();
    chk("irq tx unmasked", 32'h0000_0000, {31'h0000_0000, host_irq});
    // Byte strobes: only the low byte of a set-view write may land
    pstrb <= 4'h1;
    wr(`LMG_OFS_MASK_SET, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    exp_m = next_mask(exp_m, 32'h0000_00FF, 1'b1);
    rd(`LMG_OFS_MASK_SET, exp_m);
    chk("host saw rises", 32'h0000_0001, {31'h0000_0000, rises != 16'h0000});
    final_report();
  end
endmodule // lmg_mask_gate_tb
